// [src/pml_pkg.sv]
// constants shared by the phy-side mii and indicator logic
// assumes a 250 MHz system clock and a 25 MHz reference on a pin
package pml_pkg;

    // clock periods, in picoseconds
    localparam int CLK_PERIOD_PS     = 4000;
    localparam int TX_FAST_PERIOD_PS = 40000;
    localparam int TX_SLOW_PERIOD_PS = 400000;
    localparam logic [7:0] HALF_FAST = 8'(TX_FAST_PERIOD_PS / (2 * CLK_PERIOD_PS));
    localparam logic [7:0] HALF_SLOW = 8'(TX_SLOW_PERIOD_PS / (2 * CLK_PERIOD_PS));

    // indicator timing, counted in reference clock cycles
    localparam int REF_FREQ_KHZ    = 25000;
    localparam int ACT_STRETCH_MS  = 50;
    localparam int BLINK_MS        = 40;
    localparam int ACT_STRETCH_REF = ACT_STRETCH_MS * REF_FREQ_KHZ;
    localparam int BLINK_REF       = BLINK_MS * REF_FREQ_KHZ;
    localparam int IND_CNT_W       = 21;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_STATUS  = 8'h04;
    localparam logic [7:0] OFS_STRAP   = 8'h08;
    localparam logic [7:0] OFS_MGMT_TX = 8'h0c;
    localparam logic [7:0] OFS_MGMT_RX = 8'h10;
    localparam int         ADDR_W      = 8;

    // control fields
    localparam int          CTRL_MODE_LSB   = 0;
    localparam int          CTRL_ACTDUP_BIT = 2;
    localparam logic [2:0]  CTRL_RESET      = 3'h0;

    // indicator modes
    localparam logic [1:0] MODE_FROM_STRAP = 2'h0;
    localparam logic [1:0] LED_MODE1       = 2'h1;
    localparam logic [1:0] LED_MODE2       = 2'h2;
    localparam logic [1:0] LED_MODE3       = 2'h3;

    // management line shifter
    localparam int         MGMT_W         = 16;
    localparam int         MGMT_DRIVE_BIT = 16;
    localparam logic [4:0] MGMT_BITS      = 5'h10;

    localparam int HTRANS_ACTIVE_BIT = 1;

endpackage : pml_pkg

// [src/pml_clk_div.sv]
// clock divider producing an mii clock and its edge pulses
// assumes a synchronous reset copy and a restart from same-clock logic
`timescale 1ns/1ps
module pml_clk_div
    import pml_pkg::*;
(
    input  wire logic       clk,      // system clock
    input  wire logic       rst_n,    // synchronised reset
    input  wire logic       fast,     // 100 Mb/s rate
    input  wire logic       restart,  // realign phase
    output logic            clk_out,  // divided clock
    output logic            rise,     // clk_out goes high next cycle
    output logic            fall      // clk_out goes low next cycle
);

    logic [7:0] cnt_ff;
    logic [7:0] half;
    logic       wrap;

    assign half = fast ? HALF_FAST : HALF_SLOW;
    assign wrap = (cnt_ff >= half - 8'h01) && !restart;
    assign rise = wrap && !clk_out;
    assign fall = wrap && clk_out;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff  <= 8'h00;
            clk_out <= 1'b0;
        end else if (restart) begin
            cnt_ff  <= 8'h00;
            clk_out <= 1'b0;
        end else if (wrap) begin
            cnt_ff  <= 8'h00;
            clk_out <= !clk_out;
        end else begin
            cnt_ff  <= cnt_ff + 8'h01;
        end
    end

endmodule : pml_clk_div

// [src/pml_phy_side.sv]
// phy side of a 10/100 transceiver: mii data paths, straps, indicators
// assumes an ahb-lite master and line-side logic on clk; pins are async
`timescale 1ns/1ps
module pml_phy_side
    import pml_pkg::*;
#(
    parameter int ACT_REF   = ACT_STRETCH_REF, // activity stretch, ref cycles
    parameter int BLINK_CYC = BLINK_REF        // blink half period, ref cycles
) (
    input  wire logic        clk,                      // system clock
    input  wire logic        rst_n,                    // async reset
    input  wire logic        hsel,                     // ahb select
    input  wire logic [31:0] haddr,                    // ahb address
    input  wire logic [1:0]  htrans,                   // ahb transfer type
    input  wire logic        hwrite,                   // ahb write
    input  wire logic [2:0]  hsize,                    // ahb size
    input  wire logic [31:0] hwdata,                   // ahb write data
    input  wire logic        hready,                   // ahb bus ready
    output logic             hreadyout,                // ahb slave ready
    output logic             hresp,                    // ahb response
    output logic [31:0]      hrdata,                   // ahb read data
    input  wire logic        mdc,                      // management clock pin
    input  wire logic        mdio_in,                  // management data in
    output logic             mdio_out,                 // management data out
    output logic             mdio_oe,                  // management data drive
    output logic             mii_tx_clk,               // transmit clock
    input  wire logic        mii_tx_en,                // transmit enable
    input  wire logic [3:0]  mii_txd,                  // transmit nibble
    output logic             mii_rx_clk,               // receive clock
    output logic             recv_nibble_valid,        // receive data valid
    output logic             mii_rx_err,               // receive error
    output logic [3:0]       mii_rxd,                  // receive nibble
    output logic             carrier_sense_out,        // carrier sense
    output logic             mii_col,                  // collision
    output logic             strap_pins_oe,            // shared pins driven
    input  wire logic [4:0]  mgmt_address_strap,       // col and rxd levels
    input  wire logic        crossover_auto_strap,     // rx error pin level
    input  wire logic        indicator_mode_strap,     // carrier pin level
    input  wire logic        negotiation_strap_low,    // link pin level
    input  wire logic        negotiation_strap_high,   // rate pin level
    input  wire logic        negotiation_enable_strap, // activity pin level
    input  wire logic        reference_clock_in,       // 25 MHz reference
    output logic             crystal_drive_out,        // crystal drive
    output logic             reference_clock_fwd,      // forwarded reference
    output logic             link_indicator,           // link led
    output logic             rate_indicator,           // speed led
    output logic             activity_indicator,       // activity led
    input  wire logic        link_good,                // link status, async
    input  wire logic        link_speed100,            // 100 Mb/s, async
    input  wire logic        link_full_duplex,         // duplex, async
    input  wire logic        line_rx_carrier,          // medium not idle
    input  wire logic        line_rx_dv,               // decoded nibble valid
    input  wire logic [3:0]  line_rx_nibble,           // decoded nibble
    input  wire logic        line_rx_sym_err,          // error symbol
    output logic             line_tx_valid,            // captured nibble strobe
    output logic [3:0]       line_tx_nibble            // captured nibble
);

    function automatic logic [IND_CNT_W-1:0] dec_sat(input logic [IND_CNT_W-1:0] v);
        dec_sat = (v == '0) ? v : v - 1'b1;
    endfunction : dec_sat

    ////////////////////////////////////////////////////////////////////////
    // reset release and pin synchronisers

    logic rst_s1_ff, rst_ff;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_ff <= 1'b0;
            rst_ff    <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_ff    <= rst_s1_ff;
        end
    end

    localparam int SYN_W = 14;
    logic [SYN_W-1:0] syn_s1_ff, syn_s2_ff, syn_in;
    logic             mdc_s3_ff, ref_s3_ff;
    assign syn_in = {mii_txd, mii_tx_en, mdc, mdio_in, reference_clock_in,
                     link_good, link_speed100, link_full_duplex, 3'h0};
    always_ff @(posedge clk or negedge rst_ff) begin
        if (!rst_ff) begin
            syn_s1_ff <= '0;
            syn_s2_ff <= '0;
            mdc_s3_ff <= 1'b0;
            ref_s3_ff <= 1'b0;
        end else begin
            syn_s1_ff <= syn_in;
            syn_s2_ff <= syn_s1_ff;
            mdc_s3_ff <= syn_s2_ff[8];
            ref_s3_ff <= syn_s2_ff[6];
        end
    end

    logic [3:0] txd_s;
    logic       txen_s, mdc_s, mdio_s, ref_s, link_s, spd_s, fdx_s;
    assign txd_s  = syn_s2_ff[13:10];
    assign txen_s = syn_s2_ff[9];
    assign mdc_s  = syn_s2_ff[8];
    assign mdio_s = syn_s2_ff[7];
    assign ref_s  = syn_s2_ff[6];
    assign link_s = syn_s2_ff[5];
    assign spd_s  = syn_s2_ff[4];
    assign fdx_s  = syn_s2_ff[3];

    logic mdc_rise, mdc_fall, ref_rise;
    assign mdc_rise = mdc_s && !mdc_s3_ff;
    assign mdc_fall = !mdc_s && mdc_s3_ff;
    assign ref_rise = ref_s && !ref_s3_ff;

    ////////////////////////////////////////////////////////////////////////
    // straps, caught while reset is held, pins released to drivers after

    logic [9:0] strap_ff;
    logic [9:0] strap_s1_ff;
    always_ff @(posedge clk) begin
        strap_s1_ff <= {negotiation_enable_strap, negotiation_strap_high,
                        negotiation_strap_low, indicator_mode_strap,
                        crossover_auto_strap, mgmt_address_strap};
        if (!rst_ff) begin
            strap_ff <= strap_s1_ff;
        end
    end
    assign strap_pins_oe = rst_ff;

    ////////////////////////////////////////////////////////////////////////
    // ahb-lite register slave, zero wait states

    logic [2:0]        ctrl_ff;
    logic              ph_wr_ff;
    logic [ADDR_W-1:0] ph_addr_ff;
    logic [MGMT_W-1:0] mgmt_tx_ff, mgmt_rx_ff;
    logic              mgmt_drive_ff;
    logic [4:0]        mgmt_cnt_ff;
    logic              tx_act_ff, col_ff, crs_ff;
    logic [1:0]        mode;
    logic              acc, wr_tx;
    logic [31:0]       rd_word;

    assign acc       = hsel && htrans[HTRANS_ACTIVE_BIT] && hready;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign wr_tx     = ph_wr_ff && (ph_addr_ff == OFS_MGMT_TX);

    always_comb begin
        rd_word = 32'h0;
        unique case (haddr[ADDR_W-1:0])
            OFS_CTRL:    rd_word = {29'h0, ctrl_ff};
            OFS_STATUS:  rd_word = {24'h0, mode, tx_act_ff, col_ff, crs_ff,
                                    fdx_s, spd_s, link_s};
            OFS_STRAP:   rd_word = {22'h0, strap_ff};
            OFS_MGMT_TX: rd_word = {15'h0, mgmt_drive_ff, mgmt_tx_ff};
            OFS_MGMT_RX: rd_word = {16'h0, mgmt_rx_ff};
            default:     rd_word = 32'h0;
        endcase
        if (|haddr[31:ADDR_W]) begin
            rd_word = 32'h0;
        end
    end

    always_ff @(posedge clk or negedge rst_ff) begin
        if (!rst_ff) begin
            ph_wr_ff   <= 1'b0;
            ph_addr_ff <= '0;
            hrdata     <= 32'h0;
        end else begin
            ph_wr_ff   <= acc && hwrite && (haddr[31:ADDR_W] == '0);
            ph_addr_ff <= haddr[ADDR_W-1:0];
            if (acc && !hwrite) begin
                hrdata <= rd_word;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_ff) begin
        if (!rst_ff) begin
            ctrl_ff <= CTRL_RESET;
        end else if (ph_wr_ff && (ph_addr_ff == OFS_CTRL)) begin
            ctrl_ff <= hwdata[2:0];
        end
    end

    assign mode = (ctrl_ff[1:0] != MODE_FROM_STRAP) ? ctrl_ff[1:0] :
                  (strap_ff[6] ? LED_MODE1 : LED_MODE2);

    ////////////////////////////////////////////////////////////////////////
    // management line: shift in on mdc rise, drive 16 bits then release

    always_ff @(posedge clk or negedge rst_ff) begin
        if (!rst_ff) begin
            mgmt_rx_ff <= '0;
        end else if (mdc_rise) begin
            mgmt_rx_ff <= {mgmt_rx_ff[MGMT_W-2:0], mdio_s};
        end
    end

    always_ff @(posedge clk or negedge rst_ff) begin
        if (!rst_ff) begin
            mgmt_tx_ff    <= '0;
            mgmt_drive_ff <= 1'b0;
            mgmt_cnt_ff   <= 5'h0;
            mdio_oe       <= 1'b0;
            mdio_out      <= 1'b0;
        end else if (wr_tx) begin
            mgmt_tx_ff    <= hwdata[MGMT_W-1:0];
            mgmt_drive_ff <= hwdata[MGMT_DRIVE_BIT];
            mgmt_cnt_ff   <= 5'h0;
            mdio_oe       <= 1'b0;
        end else if (mdc_fall && mgmt_drive_ff) begin
            if (mgmt_cnt_ff == MGMT_BITS) begin
                mdio_oe       <= 1'b0;
                mgmt_drive_ff <= 1'b0;
            end else begin
                mdio_oe     <= 1'b1;
                mdio_out    <= mgmt_tx_ff[MGMT_W-1];
                mgmt_tx_ff  <= {mgmt_tx_ff[MGMT_W-2:0], 1'b0};
                mgmt_cnt_ff <= mgmt_cnt_ff + 5'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit clock and nibble capture

    logic tx_rise, rx_fall, rx_restart, carrier_d_ff;

    pml_clk_div u_tx_div (
        .clk     (clk),
        .rst_n   (rst_ff),
        .fast    (spd_s),
        .restart (1'b0),
        .clk_out (mii_tx_clk),
        .rise    (tx_rise),
        .fall    ()
    );

    always_ff @(posedge clk or negedge rst_ff) begin
        if (!rst_ff) begin
            line_tx_valid  <= 1'b0;
            line_tx_nibble <= 4'h0;
            tx_act_ff      <= 1'b0;
        end else begin
            line_tx_valid <= tx_rise && txen_s;
            if (tx_rise) begin
                tx_act_ff      <= txen_s;
                line_tx_nibble <= txen_s ? txd_s : 4'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive clock, realigned on carrier onset, rxd, valid and error change on its fall

    assign rx_restart = line_rx_carrier && !carrier_d_ff;

    pml_clk_div u_rx_div (
        .clk     (clk),
        .rst_n   (rst_ff),
        .fast    (spd_s),
        .restart (rx_restart),
        .clk_out (mii_rx_clk),
        .rise    (),
        .fall    (rx_fall)
    );

    always_ff @(posedge clk or negedge rst_ff) begin
        if (!rst_ff) begin
            carrier_d_ff      <= 1'b0;
            crs_ff            <= 1'b0;
            col_ff            <= 1'b0;
            recv_nibble_valid <= 1'b0;
            mii_rxd           <= 4'h0;
            mii_rx_err        <= 1'b0;
        end else begin
            carrier_d_ff <= line_rx_carrier;
            crs_ff       <= line_rx_carrier;
            col_ff       <= !fdx_s && tx_act_ff && line_rx_carrier;
            if (rx_fall) begin
                recv_nibble_valid <= line_rx_dv && line_rx_carrier;
                mii_rxd           <= line_rx_dv ? line_rx_nibble : 4'h0;
                mii_rx_err        <= line_rx_dv && line_rx_carrier && line_rx_sym_err;
            end
        end
    end
    assign carrier_sense_out = crs_ff;
    assign mii_col           = col_ff;

    ////////////////////////////////////////////////////////////////////////
    // reference forwarding and indicators

    logic                 act_pend_ff, blink_ff, act_evt;
    logic [IND_CNT_W-1:0] stretch_ff, blink_cnt_ff;
    assign act_evt = line_tx_valid || (rx_fall && line_rx_dv && line_rx_carrier);

    always_ff @(posedge clk or negedge rst_ff) begin
        if (!rst_ff) begin
            reference_clock_fwd <= 1'b0;
            crystal_drive_out   <= 1'b1;
        end else begin
            reference_clock_fwd <= ref_s;
            crystal_drive_out   <= !ref_s;
        end
    end

    always_ff @(posedge clk or negedge rst_ff) begin
        if (!rst_ff) begin
            act_pend_ff <= 1'b0;
        end else if (act_evt) begin
            act_pend_ff <= 1'b1;
        end else if (ref_rise) begin
            act_pend_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_ff) begin
        if (!rst_ff) begin
            stretch_ff   <= '0;
            blink_cnt_ff <= '0;
            blink_ff     <= 1'b0;
        end else if (ref_rise) begin
            if (act_pend_ff || act_evt) begin
                stretch_ff <= IND_CNT_W'(ACT_REF);
            end else begin
                stretch_ff <= dec_sat(stretch_ff);
            end
            if (blink_cnt_ff == '0) begin
                blink_cnt_ff <= IND_CNT_W'(BLINK_CYC);
                blink_ff     <= !blink_ff;
            end else begin
                blink_cnt_ff <= dec_sat(blink_cnt_ff);
            end
        end
    end

    logic busy;
    assign busy = (stretch_ff != '0);

    always_ff @(posedge clk or negedge rst_ff) begin
        if (!rst_ff) begin
            link_indicator     <= 1'b0;
            rate_indicator     <= 1'b0;
            activity_indicator <= 1'b0;
        end else if (ref_rise) begin
            rate_indicator <= spd_s;
            if (mode == LED_MODE1) begin
                link_indicator     <= link_s;
                activity_indicator <= busy;
            end else begin
                link_indicator     <= link_s && !(busy && blink_ff);
                activity_indicator <= (mode == LED_MODE3 && ctrl_ff[CTRL_ACTDUP_BIT]) ?
                                      fdx_s : busy;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_tx_high_fast;
        mii_tx_clk [*5] ##1 !mii_tx_clk;
    endsequence

    sequence s_mgmt_last;
        mdc_fall && mgmt_drive_ff && (mgmt_cnt_ff == MGMT_BITS) && !wr_tx;
    endsequence

    a_tx_clk_fast: assert property (@(posedge clk) disable iff (!rst_ff)
        $rose(mii_tx_clk) && spd_s && $past(spd_s, 2) |-> s_tx_high_fast)
        else $error("transmit clock high phase wrong at 100 Mb/s");
    a_tx_capture: assert property (@(posedge clk) disable iff (!rst_ff)
        tx_rise && txen_s |=> line_tx_valid && line_tx_nibble == $past(txd_s))
        else $error("transmit nibble not captured");
    a_tx_enable_only: assert property (@(posedge clk) disable iff (!rst_ff)
        line_tx_valid |-> $past(txen_s) && $past(tx_rise))
        else $error("transmit strobe without enable");
    a_rx_dv_edge: assert property (@(posedge clk) disable iff (!rst_ff)
        $changed(recv_nibble_valid) || $changed(mii_rxd) |-> $past(rx_fall))
        else $error("receive outputs changed off the clock fall");
    a_rx_err_pkt: assert property (@(posedge clk) disable iff (!rst_ff)
        mii_rx_err |-> recv_nibble_valid)
        else $error("receive error outside a packet");
    a_crs_track: assert property (@(posedge clk) disable iff (!rst_ff)
        $rose(line_rx_carrier) |=> carrier_sense_out ##1 (carrier_sense_out || !line_rx_carrier))
        else $error("carrier sense missed medium activity");
    a_col_fdx: assert property (@(posedge clk) disable iff (!rst_ff)
        fdx_s && $past(fdx_s) |-> !mii_col)
        else $error("collision in full duplex");
    a_col_hdx: assert property (@(posedge clk) disable iff (!rst_ff)
        mii_col |-> $past(tx_act_ff) && $past(line_rx_carrier))
        else $error("collision without both media busy");
    a_mdio_release: assert property (@(posedge clk) disable iff (!rst_ff)
        s_mgmt_last |=> !mdio_oe [*2])
        else $error("management line not released");
    a_strap_hold: assert property (@(posedge clk) disable iff (!rst_ff)
        $past(rst_ff) |-> $stable(strap_ff) && strap_pins_oe)
        else $error("strap value changed after reset");
    a_rate_led: assert property (@(posedge clk) disable iff (!rst_ff)
        ref_rise |=> rate_indicator == $past(spd_s))
        else $error("rate indicator wrong");
    a_act_stretch: assert property (@(posedge clk) disable iff (!rst_ff)
        ref_rise && act_pend_ff && mode == LED_MODE1 |=> ##[0:24] activity_indicator)
        else $error("activity not shown");
    a_link_mode1: assert property (@(posedge clk) disable iff (!rst_ff)
        ref_rise && mode == LED_MODE1 |=> link_indicator == $past(link_s))
        else $error("link indicator wrong in mode 1");

endmodule : pml_phy_side

// [bench/pml_mac_model.sv]
// mac partner: sends counting nibbles on the phy transmit clock
// assumes tx_clk comes from the phy side and go is held for a frame
`timescale 1ns/1ps
module pml_mac_model (
    input  wire logic       tx_clk, // phy transmit clock
    input  wire logic       go,     // send while high
    output logic            tx_en,  // transmit enable
    output logic [3:0]      txd     // transmit nibble
);
    initial begin
        tx_en = 1'b0;
        txd   = 4'h0;
    end
    always @(posedge tx_clk) begin
        tx_en <= go;
        txd   <= go ? txd + 4'h1 : ~txd;
    end
endmodule : pml_mac_model

// [bench/pml_phy_side_bench.sv]
// bench for the phy side: ahb registers, mii paths, mdio, indicators
// assumes the mac model on the transmit side and a pulled-up mdio wire
`timescale 1ns/1ps
module pml_phy_side_bench
    import pml_pkg::*;
;
    logic clk, rst_n, hsel, hwrite, mdc, mii_tx_en, reference_clock_in, go;
    logic link_good, link_speed100, link_full_duplex, hreadyout, hresp;
    logic line_rx_carrier, line_rx_dv, line_rx_sym_err, mdio_out, mdio_oe;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  mii_txd, line_rx_nibble, mii_rxd, line_tx_nibble;
    logic [4:0]  mgmt_address_strap;
    logic [9:0]  straps;
    logic crossover_auto_strap, indicator_mode_strap, negotiation_strap_low;
    logic negotiation_strap_high, negotiation_enable_strap, mii_tx_clk, mii_rx_clk;
    logic recv_nibble_valid, mii_rx_err, carrier_sense_out, mii_col, strap_pins_oe;
    logic crystal_drive_out, reference_clock_fwd, link_indicator, rate_indicator;
    logic activity_indicator, line_tx_valid;
    int   mismatches, samples_checked, cyc, n;
    // rows: carrier, dv, err, nibble | crs, dv, err
    logic [9:0] rows [5] = '{10'h000, 10'h2ac, 10'h356, 10'h39f, 10'h1e0};
    wire  mdio_in = mdio_oe ? mdio_out : 1'b1;
    assign {negotiation_enable_strap, negotiation_strap_high, negotiation_strap_low,
            indicator_mode_strap, crossover_auto_strap, mgmt_address_strap} = straps;
    pml_phy_side #(.ACT_REF(20), .BLINK_CYC(8)) i_pml_phy_side (.*, .hready(hreadyout));
    pml_mac_model i_pml_mac_model (.tx_clk(mii_tx_clk), .go(go), .tx_en(mii_tx_en),
                                   .txd(mii_txd));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        hsize  <= 3'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task automatic wrap_up;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        reference_clock_in = 1'b0;
        forever #20 reference_clock_in = ~reference_clock_in;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            wrap_up();
        end
    end
    initial begin
        {hsel, hwrite, htrans, hsize, haddr, hwdata, go, rst_n} = '0;
        {mdc, link_good, link_speed100, link_full_duplex} = 4'hf;
        {line_rx_carrier, line_rx_dv, line_rx_sym_err, line_rx_nibble} = '0;
        straps = 10'h365;
        repeat (2) @(posedge clk);
        chk({hresp, hreadyout, strap_pins_oe, crystal_drive_out}, 4'b0101);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        straps <= 10'h09a;
        ahb(1, OFS_STRAP, '1);
        ahb(0, OFS_STRAP, 0);
        chk(rd, 32'h365);
        ahb(0, 8'hfc, 0);
        chk(rd, 0);
        ahb(0, OFS_STATUS, 0);
        chk(rd, 32'h47);
        @(posedge reference_clock_fwd) n = cyc;
        @(posedge reference_clock_fwd) chk(cyc - n, 10);
        $display("reset and straps done");
        foreach (rows[i]) begin
            {line_rx_carrier, line_rx_dv, line_rx_sym_err, line_rx_nibble} <= rows[i][9:3];
            repeat (30) @(posedge clk);
            chk({mii_col, carrier_sense_out, recv_nibble_valid, mii_rx_err},
                rows[i][2:0]);
            if (rows[i][1]) chk(mii_rxd, rows[i][6:3]);
        end
        $display("receive rows done");
        {go, link_full_duplex, line_rx_carrier} <= 3'b101;
        repeat (60) @(posedge clk);
        chk(mii_col, 1);
        do @(posedge clk); while (line_tx_valid !== 1'b1);
        n = line_tx_nibble;
        do @(posedge clk); while (line_tx_valid !== 1'b1);
        chk(line_tx_nibble, 4'(n + 1));
        link_full_duplex <= 1'b1;
        repeat (20) @(posedge clk);
        chk(mii_col, 0);
        ahb(1, OFS_CTRL, LED_MODE1);
        repeat (200) @(posedge clk);
        chk({link_indicator, activity_indicator}, 2'b11);
        for (int s = 1; s >= 0; s--) begin
            link_speed100 <= 1'(s);
            repeat (300) @(posedge clk);
            @(posedge mii_tx_clk) n = cyc;
            @(posedge mii_tx_clk) chk(cyc - n, s ? 10 : 100);
            chk(rate_indicator, s);
            @(posedge mii_rx_clk) n = cyc;
            @(posedge mii_rx_clk) chk(cyc - n, s ? 10 : 100);
        end
        $display("transmit and speed done");
        ahb(1, OFS_CTRL, LED_MODE2);
        n = 0;
        repeat (600) @(posedge clk) n += !link_indicator;
        chk(n > 0 && n < 600, 1);
        {go, line_rx_carrier, link_good} <= 3'b000;
        ahb(1, OFS_CTRL, LED_MODE1);
        repeat (400) @(posedge clk);
        chk({link_indicator, activity_indicator}, 2'b00);
        ahb(1, OFS_CTRL, 32'h7);
        repeat (200) @(posedge clk);
        chk(activity_indicator, 1);
        ahb(1, OFS_MGMT_TX, 32'h1b3c5);
        repeat (33) begin
            repeat (10) @(posedge clk);
            mdc <= ~mdc;
        end
        repeat (20) @(posedge clk);
        ahb(0, OFS_MGMT_RX, 0);
        chk({mdio_oe, rd[30:0]}, 32'hb3c5);
        $display("indicators and mdio done");
        wrap_up();
    end
endmodule : pml_phy_side_bench
